/* hdl/line_mode_pkg.sv */
// Constants, field layouts and state codes for the line-mode, auto-cycle and power-down control.
// Assumes a single 100 MHz master clock and an 8-bit register port with 8-bit addresses.
package line_mode_pkg;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Register addresses on the plain register port.
    localparam logic [7:0] ADDR_LINE_MODE = 8'h04;
    localparam logic [7:0] ADDR_POWER_DOWN = 8'h05;
    localparam logic [7:0] ADDR_CYCLE_RESET = 8'h06;
    localparam logic [7:0] ADDR_MISC_SETUP = 8'h07;
    localparam logic [7:0] ADDR_STATUS = 8'h08;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Widths, reset values and encodings.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;
    localparam logic [1:0] SEL_RED = 2'h0;
    localparam logic [1:0] SEL_GREEN = 2'h1;
    localparam logic [1:0] SEL_BLUE = 2'h2;
    localparam logic [1:0] CHAN_RED = 2'h0;
    localparam int NUM_COLOURS = 3;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Line-mode setup fields, bits 3:0; bits 7:4 read as zero.
    typedef struct packed {
        logic [1:0] manual_gain_offset_sel;
        logic auto_cycle_en;
        logic line_mode_en;
    } line_mode_setup_t;
    localparam line_mode_setup_t LINE_MODE_RESET = 4'h0;

    // Power-down setup fields, bits 4:0; bits 7:5 read as zero.
    typedef struct packed {
        logic ref_level_dac_powerdown;
        logic converter_powerdown;
        logic blue_stage_powerdown;
        logic green_stage_powerdown;
        logic red_stage_powerdown;
    } power_down_setup_t;
    localparam power_down_setup_t POWER_DOWN_RESET = 5'h00;

    // Loose control bits gathered into one register, bits 4:0.
    typedef struct packed {
        logic correlated_sampling_en;
        logic clamp_control_bit;
        logic [1:0] channel_select;
        logic single_channel_mode;
    } misc_setup_t;
    localparam misc_setup_t MISC_RESET = 5'h00;

    // Status read-back: bit 5 clamp enable, 4:3 channel, 2 single channel, 1:0 gain/offset set.
    typedef struct packed {
        logic clamp_enable;
        logic [1:0] eff_channel_select;
        logic eff_single_channel;
        logic [1:0] gain_offset_sel;
    } status_t;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Auto-cycle position, one-hot.
    typedef enum logic [2:0] {
        POS_RED = 3'h1,
        POS_GREEN = 3'h2,
        POS_BLUE = 3'h4
    } cycle_pos_t;

endpackage

/* hdl/pin_edge_sync.sv */
// Synchroniser and rising-edge detector for the reset-sample pin.
// Assumes the pin is asynchronous to mclk; the edge pulse is one mclk cycle long.
module pin_edge_sync
    import line_mode_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rstn,
    // Pin and detected edge.
    input wire logic pin,
    output logic rise
);

    logic meta;
    logic stable;
    logic stable_d;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Two-flop synchroniser; the first stage feeds only the second.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            meta <= 1'b0;
            stable <= 1'b0;
        end else begin
            meta <= pin;
            stable <= meta;
        end
    end

    // Registered rising-edge pulse taken from the synchronised level.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            stable_d <= 1'b0;
            rise <= 1'b0;
        end else begin
            stable_d <= stable;
            rise <= stable & ~stable_d;
        end
    end

    chk_one_edge_pulse: assert property (
        @(posedge mclk) disable iff (!rstn)
        rise |=> !rise
    ) else $error("Edge pulse lasted more than one cycle.");

endmodule // pin_edge_sync

/* hdl/line_mode_ctrl.sv */
// Line-mode, auto-cycle and power-down control for a three-channel imaging front end.
// Assumes registers reached over a plain port clocked by mclk; reset-sample pin is asynchronous.
//
// Design decisions made here: the strobed register port and the register offsets.
module line_mode_ctrl
    import line_mode_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rstn,
    // Register port.
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    // Reset-sample pin from the timing generator.
    input wire logic reset_sample_pin,
    // Effective channel configuration.
    output logic eff_single_channel,
    output logic [1:0] eff_channel_select,
    output logic [1:0] gain_offset_sel,
    // Clamp and sampling control.
    output logic clamp_from_pin,
    output logic clamp_enable,
    output logic correlated_sampling_en,
    // Power-down controls.
    output logic [NUM_COLOURS-1:0] stage_powerdown,
    output logic converter_powerdown,
    output logic ref_level_dac_powerdown,
    output logic ref_level_dac_oe
);

    line_mode_setup_t line_mode_setup;
    power_down_setup_t power_down_setup;
    misc_setup_t misc_setup;
    cycle_pos_t pos;
    cycle_pos_t next_pos;
    status_t status;
    logic pin_rise;
    logic cycling;
    logic cycle_reset_wr;

    // Maps a cycle position to its gain/offset set code.
    function automatic logic [1:0] pos_to_sel(input cycle_pos_t p);
        logic [1:0] s;
        s = SEL_RED;
        unique case (p)
            POS_RED: s = SEL_RED;
            POS_GREEN: s = SEL_GREEN;
            POS_BLUE: s = SEL_BLUE;
            default: s = SEL_RED;
        endcase
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Register writes; unmapped and status addresses are ignored.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            line_mode_setup <= LINE_MODE_RESET;
            power_down_setup <= POWER_DOWN_RESET;
            misc_setup <= MISC_RESET;
        end else if (wr) begin
            if (addr == ADDR_LINE_MODE) begin
                line_mode_setup <= wdata[$bits(line_mode_setup_t)-1:0];
            end
            if (addr == ADDR_POWER_DOWN) begin
                power_down_setup <= wdata[$bits(power_down_setup_t)-1:0];
            end
            if (addr == ADDR_MISC_SETUP) begin
                misc_setup <= wdata[$bits(misc_setup_t)-1:0];
            end
        end
    end

    // Auto-cycling only counts when line mode is on.
    assign cycling = line_mode_setup.line_mode_en & line_mode_setup.auto_cycle_en;
    assign cycle_reset_wr = wr && (addr == ADDR_CYCLE_RESET);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Reset-sample pin synchroniser and edge detector.
    pin_edge_sync u_pin_sync (
        .mclk(mclk),
        .rstn(rstn),
        .pin(reset_sample_pin),
        .rise(pin_rise)
    );

    // Next cycle position: reset write wins over a pin edge in the same cycle.
    always_comb begin
        next_pos = pos;
        if (cycle_reset_wr) begin
            next_pos = POS_RED;
        end else if (pin_rise && cycling) begin
            unique case (pos)
                POS_RED: next_pos = POS_GREEN;
                POS_GREEN: next_pos = POS_BLUE;
                POS_BLUE: next_pos = POS_RED;
                default: next_pos = POS_RED;
            endcase
        end
    end

    // Cycle position register.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pos <= POS_RED;
        end else begin
            pos <= next_pos;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Effective channel configuration and gain/offset set selection.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            eff_single_channel <= 1'b0;
            eff_channel_select <= CHAN_RED;
            gain_offset_sel <= SEL_RED;
        end else if (line_mode_setup.line_mode_en) begin
            eff_single_channel <= 1'b1;
            eff_channel_select <= CHAN_RED;
            if (line_mode_setup.auto_cycle_en) begin
                gain_offset_sel <= pos_to_sel(pos);
            end else begin
                gain_offset_sel <= line_mode_setup.manual_gain_offset_sel;
            end
        end else begin
            eff_single_channel <= misc_setup.single_channel_mode;
            eff_channel_select <= misc_setup.channel_select;
            gain_offset_sel <= misc_setup.channel_select;
        end
    end

    // Clamp source: the pin unless auto-cycling, then the clamp-control bit.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            clamp_from_pin <= 1'b1;
            clamp_enable <= 1'b0;
            correlated_sampling_en <= 1'b0;
        end else begin
            clamp_from_pin <= ~cycling;
            clamp_enable <= cycling & misc_setup.clamp_control_bit;
            // The host keeps this clear while cycling; it is passed as written.
            correlated_sampling_en <= misc_setup.correlated_sampling_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Colour stage power-down; line mode also stops green and blue.
    generate
        for (genvar i = 0; i < NUM_COLOURS; i++) begin : g_stage_pd
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    stage_powerdown[i] <= 1'b0;
                end else if (i == 0) begin
                    stage_powerdown[i] <= power_down_setup[i];
                end else begin
                    stage_powerdown[i] <= power_down_setup[i] |
                        line_mode_setup.line_mode_en;
                end
            end
        end
    endgenerate

    // Converter and reference-level DAC power-down; references are untouched.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            converter_powerdown <= 1'b0;
            ref_level_dac_powerdown <= 1'b0;
            ref_level_dac_oe <= 1'b1;
        end else begin
            converter_powerdown <= power_down_setup.converter_powerdown;
            ref_level_dac_powerdown <= power_down_setup.ref_level_dac_powerdown;
            ref_level_dac_oe <= ~power_down_setup.ref_level_dac_powerdown;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Read data, valid only in the cycle after the read strobe.
    assign status = '{clamp_enable: clamp_enable, eff_channel_select: eff_channel_select,
                      eff_single_channel: eff_single_channel, gain_offset_sel: gain_offset_sel};

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata <= RDATA_IDLE;
        end else if (rd) begin
            unique case (addr)
                ADDR_LINE_MODE: rdata <= DATA_W'(line_mode_setup);
                ADDR_POWER_DOWN: rdata <= DATA_W'(power_down_setup);
                ADDR_MISC_SETUP: rdata <= DATA_W'(misc_setup);
                ADDR_STATUS: rdata <= DATA_W'(status);
                default: rdata <= RDATA_IDLE;
            endcase
        end else begin
            rdata <= RDATA_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Checks on the effective controls.
    chk_line_forces_single_channel_mode: assert property (
        @(posedge mclk) disable iff (!rstn)
        line_mode_setup.line_mode_en |=> eff_single_channel && eff_channel_select == CHAN_RED
    ) else $error("Line mode did not force single red channel.");

    chk_line_gates_gb: assert property (
        @(posedge mclk) disable iff (!rstn)
        line_mode_setup.line_mode_en |=> stage_powerdown[NUM_COLOURS-1:1] == 2'h3
    ) else $error("Green or blue stage left on in line mode.");

    chk_cycle_bit_ignored: assert property (
        @(posedge mclk) disable iff (!rstn)
        !line_mode_setup.line_mode_en |=> clamp_from_pin && !clamp_enable
    ) else $error("Auto-cycle bit acted outside line mode.");

    chk_manual_set_sel: assert property (
        @(posedge mclk) disable iff (!rstn)
        line_mode_setup.line_mode_en && !line_mode_setup.auto_cycle_en
        |=> gain_offset_sel == $past(line_mode_setup.manual_gain_offset_sel) && clamp_from_pin
    ) else $error("Manual gain/offset selection not applied.");

    chk_cycle_red_green: assert property (
        @(posedge mclk) disable iff (!rstn)
        pin_rise && cycling && !cycle_reset_wr && pos == POS_RED
        |=> pos == POS_GREEN ##1 gain_offset_sel == SEL_GREEN || !cycling
    ) else $error("Auto-cycle did not step from red to green.");

    chk_cycle_blue_red: assert property (
        @(posedge mclk) disable iff (!rstn)
        pin_rise && cycling && !cycle_reset_wr && pos == POS_BLUE |=> pos == POS_RED
    ) else $error("Auto-cycle did not wrap from blue to red.");

    chk_clamp_bit_used: assert property (
        @(posedge mclk) disable iff (!rstn)
        cycling |=> !clamp_from_pin && clamp_enable == $past(misc_setup.clamp_control_bit)
    ) else $error("Clamp not taken from clamp-control bit while cycling.");

    chk_red_stage_pd: assert property (
        @(posedge mclk) disable iff (!rstn)
        $rose(power_down_setup.red_stage_powerdown) |=> stage_powerdown[0] ##1 stage_powerdown[0]
            || !power_down_setup.red_stage_powerdown
    ) else $error("Red stage power-down not applied.");

    chk_converter_pd: assert property (
        @(posedge mclk) disable iff (!rstn)
        power_down_setup.converter_powerdown && !power_down_setup.ref_level_dac_powerdown
        |=> converter_powerdown && ref_level_dac_oe
    ) else $error("Converter power-down disturbed the DAC.");

    chk_dac_hiz: assert property (
        @(posedge mclk) disable iff (!rstn)
        power_down_setup.ref_level_dac_powerdown |=> ref_level_dac_powerdown && !ref_level_dac_oe
    ) else $error("Reference DAC not released to high impedance.");

    chk_cycle_reset_red: assert property (
        @(posedge mclk) disable iff (!rstn)
        cycle_reset_wr |=> pos == POS_RED
    ) else $error("Cycle-reset write did not return to red.");

    chk_single_channel_mode_channel: assert property (
        @(posedge mclk) disable iff (!rstn)
        !line_mode_setup.line_mode_en |=> eff_channel_select == $past(misc_setup.channel_select)
    ) else $error("Channel select not followed outside line mode.");

    // Sequencing checks: the middle step, ignored pins and an ignored manual select.
    chk_cycle_green_blue: assert property (
        @(posedge mclk) disable iff (!rstn)
        pin_rise && cycling && !cycle_reset_wr && pos == POS_GREEN |=> pos == POS_BLUE
    ) else $error("Auto-cycle did not step from green to blue.");

    chk_pins_ignored: assert property (
        @(posedge mclk) disable iff (!rstn)
        pin_rise && !cycling && !cycle_reset_wr |=> pos == $past(pos)
    ) else $error("Pin pulse moved the sequence while not cycling.");

    chk_cycle_ignores_manual: assert property (
        @(posedge mclk) disable iff (!rstn)
        cycling && pos == POS_RED |=> gain_offset_sel == SEL_RED
    ) else $error("Manual select acted while auto-cycling.");

    // Power-down checks for the other colour stages and the driven reference DAC.
    chk_green_stage_pd: assert property (
        @(posedge mclk) disable iff (!rstn)
        power_down_setup.green_stage_powerdown |=> stage_powerdown[1]
    ) else $error("Green stage power-down not applied.");

    chk_blue_stage_pd: assert property (
        @(posedge mclk) disable iff (!rstn)
        power_down_setup.blue_stage_powerdown |=> stage_powerdown[2]
    ) else $error("Blue stage power-down not applied.");

    chk_dac_driven: assert property (
        @(posedge mclk) disable iff (!rstn)
        !power_down_setup.ref_level_dac_powerdown |=> ref_level_dac_oe && !ref_level_dac_powerdown
    ) else $error("Reference DAC not driving while powered.");

endmodule // line_mode_ctrl

/* tb/pulse_source.sv */
// Behavioural model of the sensor timing generator that drives the reset-sample pin.
// Assumes the bench asks for one pulse at a time; widths are counted in mclk cycles.
module pulse_source (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rstn,
    // Pulse request from the bench.
    input wire logic go,
    input wire logic [3:0] hi_len,
    input wire logic [3:0] lo_len,
    // Pin towards the front end.
    output logic pin,
    output logic busy
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [3:0] cnt;

    ////////////////////////////////////////////////////////////////////////////////////////
    // A high phase, then a low phase; both last two cycles or more so each pulse counts once.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pin <= 1'b0;
            busy <= 1'b0;
            cnt <= 4'h0;
        end else if (!busy && go) begin
            pin <= 1'b1;
            busy <= 1'b1;
            cnt <= (hi_len < 4'h2) ? 4'h2 : hi_len;
        end else if (busy) begin
            if (cnt > 4'h1) begin
                cnt <= cnt - 4'h1;
            end else if (pin) begin
                pin <= 1'b0;
                cnt <= (lo_len < 4'h2) ? 4'h2 : lo_len;
            end else begin
                busy <= 1'b0;
            end
        end
    end
endmodule // pulse_source

/* tb/line_mode_autocycle_powerdown_tb.sv */
// Self-checking bench: a table of register settings, then auto-cycle, read-back and reset cases.
// Assumes the design package and the pulse_source model of the timing generator.
module line_mode_autocycle_powerdown_tb import line_mode_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [7:0] lm;
        logic [7:0] pd;
        logic [7:0] misc;
        logic [13:0] exp;
    } row_t;

    logic mclk, rstn, wr, rd, go, busy, pin;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [3:0] hi_len, lo_len;
    logic eff_single_channel, clamp_from_pin, clamp_enable, correlated_sampling_en;
    logic converter_powerdown, ref_level_dac_powerdown, ref_level_dac_oe;
    logic [1:0] eff_channel_select, gain_offset_sel;
    logic [NUM_COLOURS-1:0] stage_powerdown;
    logic [13:0] outs;
    int err_count = 0;
    int check_count = 0;
    // Setting rows: line mode, power down, misc, then the control outputs they give.
    row_t rows [8] = '{'{8'h00, 8'h00, 8'h00, 14'h0101}, '{8'h0e, 8'h01, 8'h0d, 14'h3509},
        '{8'h01, 8'h00, 8'h07, 14'h2131}, '{8'h05, 8'h02, 8'h10, 14'h2371},
        '{8'h09, 8'h08, 8'h00, 14'h2535}, '{8'h0d, 8'h10, 8'h00, 14'h2732},
        '{8'h0f, 8'h04, 8'h08, 14'h20b1}, '{8'h03, 8'h1f, 8'h00, 14'h203e}};
    logic [1:0] seq [4] = '{SEL_GREEN, SEL_BLUE, SEL_RED, SEL_GREEN};

    // All control outputs gathered into one vector for comparison.
    assign outs = {eff_single_channel, eff_channel_select, gain_offset_sel, clamp_from_pin,
        clamp_enable, correlated_sampling_en, stage_powerdown, converter_powerdown,
        ref_level_dac_powerdown, ref_level_dac_oe};

    ////////////////////////////////////////////////////////////////////////////////////////
    // Design and timing generator model.
    line_mode_ctrl uut (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .reset_sample_pin(pin), .eff_single_channel(eff_single_channel),
        .eff_channel_select(eff_channel_select), .gain_offset_sel(gain_offset_sel),
        .clamp_from_pin(clamp_from_pin), .clamp_enable(clamp_enable),
        .correlated_sampling_en(correlated_sampling_en), .stage_powerdown(stage_powerdown),
        .converter_powerdown(converter_powerdown),
        .ref_level_dac_powerdown(ref_level_dac_powerdown), .ref_level_dac_oe(ref_level_dac_oe));
    pulse_source timing_gen (.mclk(mclk), .rstn(rstn), .go(go), .hi_len(hi_len),
        .lo_len(lo_len), .pin(pin), .busy(busy));

    // Master clock at 100 MHz.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Reporting and comparison.
    task automatic fail(input string msg);
        err_count++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask

    task automatic report_and_stop();
        $display("mismatches %0d, comparisons %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk_out(input logic [13:0] exp);
        check_count++;
        if (outs !== exp) fail($sformatf("outputs %h, wanted %h", outs, exp));
    endtask

    task automatic chk_rd(input logic [7:0] exp);
        check_count++;
        if (rdata !== exp) fail($sformatf("read data %h, wanted %h", rdata, exp));
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    // Register port cycles; read data are compared in the one cycle they stand.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk_rd(exp);
    endtask

    task automatic settle();
        repeat (3) @(posedge mclk);
        #1;
    endtask

    // One pin pulse from the timing generator, waited for under a bound.
    task automatic pulse(input logic [3:0] hi, input logic [3:0] lo);
        int n = 0;
        @(posedge mclk);
        go <= 1'b1;
        hi_len <= hi;
        lo_len <= lo;
        @(posedge mclk);
        go <= 1'b0;
        do begin
            @(posedge mclk);
            n++;
        end while (busy === 1'b1 && n < 64);
        if (n >= 64) begin
            fail("pulse never finished");
            report_and_stop();
        end
        settle();
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        rstn = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        go = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        hi_len = 4'h2;
        lo_len = 4'h2;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        #1;
        chk_out(14'h0101);
        rd_reg(ADDR_LINE_MODE, 8'h00);
        rd_reg(ADDR_POWER_DOWN, 8'h00);
        // Table of settings, each also read back through the status register.
        foreach (rows[i]) begin
            wr_reg(ADDR_LINE_MODE, rows[i].lm);
            wr_reg(ADDR_POWER_DOWN, rows[i].pd);
            wr_reg(ADDR_MISC_SETUP, rows[i].misc);
            settle();
            chk_out(rows[i].exp);
            chk_out(rows[i].exp);
            rd_reg(ADDR_STATUS, {2'h0, rows[i].exp[7], rows[i].exp[12:11], rows[i].exp[13],
                rows[i].exp[10:9]});
        end
        // Reserved bits, write-only reset place and an unmapped place.
        wr_reg(ADDR_LINE_MODE, 8'hff);
        rd_reg(ADDR_LINE_MODE, 8'h0f);
        wr_reg(ADDR_POWER_DOWN, 8'hff);
        rd_reg(ADDR_POWER_DOWN, 8'h1f);
        rd_reg(ADDR_CYCLE_RESET, 8'h00);
        wr_reg(8'h3c, 8'hff);
        rd_reg(8'h3c, 8'h00);
        // Auto-cycling with clamp bit set and correlated sampling kept clear.
        wr_reg(ADDR_POWER_DOWN, 8'h00);
        wr_reg(ADDR_MISC_SETUP, 8'h08);
        wr_reg(ADDR_LINE_MODE, 8'h03);
        wr_reg(ADDR_CYCLE_RESET, 8'h5a);
        settle();
        chk_out(14'h20b1);
        foreach (seq[i]) begin
            pulse(i[0] ? 4'h8 : 4'h2, i[0] ? 4'h8 : 4'h2);
            chk_out(14'h20b1 | {3'h0, seq[i], 9'h000});
        end
        wr_reg(ADDR_CYCLE_RESET, 8'h00);
        settle();
        chk_out(14'h20b1);
        pulse(4'h3, 4'h2);
        // Pin pulses outside auto-cycling must not move the sequence.
        wr_reg(ADDR_LINE_MODE, 8'h01);
        pulse(4'h2, 4'h2);
        chk_out(14'h2131);
        wr_reg(ADDR_LINE_MODE, 8'h02);
        pulse(4'h2, 4'h2);
        wr_reg(ADDR_LINE_MODE, 8'h03);
        settle();
        chk_out(14'h22b1);
        // Reset in mid-run.
        @(posedge mclk);
        rstn <= 1'b0;
        #1;
        chk_out(14'h0101);
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        settle();
        chk_out(14'h0101);
        rd_reg(ADDR_LINE_MODE, 8'h00);
        report_and_stop();
    end
endmodule // line_mode_autocycle_powerdown_tb
